/* File: common/llpes_defs.svh */
// Purpose: constants for link-layer event selection
// Assumes: included by package and design files
// Notes: field positions follow the 33-bit selection word
`ifndef LLPES_DEFS_SVH
`define LLPES_DEFS_SVH

`define LLPES_REG_W 33
`define LLPES_PART_W 32
`define LLPES_RESET_VAL 33'h000000000
`define LLPES_SEL_MSB 32
`define LLPES_SEL_LSB 28
`define LLPES_EVT_MSB 27
`define LLPES_EVT_LSB 25
`define LLPES_HIGH_BIT 32

`define LLPES_EVT_NONE 3'h0
`define LLPES_EVT_PKT 3'h1
`define LLPES_EVT_PKT_IDLE 3'h2
`define LLPES_EVT_FLIT 3'h3
`define LLPES_EVT_STALL 3'h4

`define LLPES_LANE_0 5'h0D
`define LLPES_LANE_1 5'h0E
`define LLPES_LANE_2 5'h0F
`define LLPES_LANE_3 5'h10
`define LLPES_LANE_01 5'h11
`define LLPES_LANE_23 5'h12
`define LLPES_LANE_ALL 5'h13
`define LLPES_LANE_ALL_HUB 5'h14

`define LLPES_INST_COHERENT 4
`define LLPES_INST_HUB 2
`define LLPES_INST_EXTENDED 3

`endif

/* File: common/llpes_pkg.sv */
// Purpose: types for link-layer event selection
// Assumes: llpes_defs.svh on the include path
// Notes: lane mask decode shared by both selection registers
`include "llpes_defs.svh"

package llpes_pkg;

  // which part of a selection register an access touches
  typedef enum logic {
    LLPES_PART_LOW = 1'b0,
    LLPES_PART_HIGH = 1'b1
  } llpes_part_type;

  // output_buffer to link_layer_unit traffic seen by one instance
  typedef struct packed {
    logic packet;
    logic packet_idle;
    logic [3:0] flit_lanes;
    logic stall;
  } llpes_ob_evt_type;

  // one configuration access
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] inst;
    logic reg_sel;
    llpes_part_type part;
    logic [31:0] wdata;
  } llpes_cfg_type;

  // lane mask from the select field; hub-only code honoured on hub side
  function automatic logic [3:0] llpes_lane_mask(input logic [4:0] sel, input logic hub);
    logic [3:0] m;
    m = 4'hF;
    case (sel)
      `LLPES_LANE_0: m = 4'h1;
      `LLPES_LANE_1: m = 4'h2;
      `LLPES_LANE_2: m = 4'h4;
      `LLPES_LANE_3: m = 4'h8;
      `LLPES_LANE_01: m = 4'h3;
      `LLPES_LANE_23: m = 4'hC;
      `LLPES_LANE_ALL: m = 4'hF;
      `LLPES_LANE_ALL_HUB: m = hub ? 4'hF : 4'h0;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

endpackage

/* File: src/llpes_inst.sv */
// Purpose: one link-layer instance with its two selection registers
// Assumes: configuration writes arrive one per cycle
// Notes: read data and event hits leave from registers
`timescale 1ns/1ps
`include "llpes_defs.svh"

module llpes_inst
  import llpes_pkg::*;
#(
  parameter bit HUB_SIDE = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic reg_sel_in,
  input wire llpes_part_type part_in,
  input wire logic [31:0] wdata_in,
  input wire llpes_ob_evt_type evt_in,
  output logic [31:0] rdata_out,
  output logic [1:0] hit_out
);

  logic [`LLPES_REG_W-1:0] sel_q [2];
  logic [`LLPES_REG_W-1:0] sel_d [2];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] hit_q;
  logic [1:0] hit_d;

  // register update: low word or lone high bit
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      sel_d[r] = sel_q[r];
      if (wr_en_in && (reg_sel_in == r[0])) begin
        if (part_in == LLPES_PART_LOW) begin
          sel_d[r][`LLPES_PART_W-1:0] = wdata_in;
        end else begin
          sel_d[r][`LLPES_HIGH_BIT] = wdata_in[0];
        end
      end
    end
  end

  // read mux, high part zero-extended
  always_comb begin
    if (part_in == LLPES_PART_LOW) begin
      rdata_d = sel_q[reg_sel_in][`LLPES_PART_W-1:0];
    end else begin
      rdata_d = {31'h00000000, sel_q[reg_sel_in][`LLPES_HIGH_BIT]};
    end
  end

  // interface event decode per register
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      case (sel_q[r][`LLPES_EVT_MSB:`LLPES_EVT_LSB])
        `LLPES_EVT_NONE: hit_d[r] = 1'b0;
        `LLPES_EVT_PKT: hit_d[r] = evt_in.packet;
        `LLPES_EVT_PKT_IDLE: hit_d[r] = evt_in.packet_idle;
        `LLPES_EVT_FLIT: hit_d[r] = |(evt_in.flit_lanes &
          llpes_lane_mask(sel_q[r][`LLPES_SEL_MSB:`LLPES_SEL_LSB], HUB_SIDE));
        `LLPES_EVT_STALL: hit_d[r] = evt_in.stall;
        default: hit_d[r] = 1'b0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_q[0] <= `LLPES_RESET_VAL;
      sel_q[1] <= `LLPES_RESET_VAL;
      rdata_q <= 32'h00000000;
      hit_q <= 2'h0;
    end else begin
      sel_q[0] <= sel_d[0];
      sel_q[1] <= sel_d[1];
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign rdata_out = rdata_q;
  assign hit_out = hit_q;

endmodule

/* File: src/llpes_top.sv */
// Purpose: event selection for all instances of one link-layer unit
// Assumes: configuration port and traffic inputs synchronous to sys_clk_in
// Notes: read answer two cycles after the request
//   writes land on the taking edge, so a read right behind sees them
//   writes naming a missing instance are dropped but still answered
//   reads of a missing instance answer zero
//   hit bits pair per instance: even bit register a, odd bit register b
`timescale 1ns/1ps
`include "llpes_defs.svh"

module llpes_top
  import llpes_pkg::*;
#(
  parameter int NUM_INST = `LLPES_INST_COHERENT,
  parameter bit HUB_SIDE = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire llpes_cfg_type cfg_in,
  input wire llpes_ob_evt_type evt_in [NUM_INST],
  output logic cfg_ack_out,
  output logic [31:0] cfg_rdata_out,
  output logic [2*NUM_INST-1:0] event_hit_out
);

  // per-instance wiring
  logic [NUM_INST-1:0] wr_en;
  logic [NUM_INST-1:0] rd_sel;
  logic [31:0] inst_rdata [NUM_INST];
  logic [1:0] inst_hit [NUM_INST];

  // stage one: request taken, instance chosen
  logic pend_q;
  logic pend_d;
  logic write_q;
  logic write_d;
  logic [3:0] rd_inst_q;
  logic [3:0] rd_inst_d;
  logic in_range_q;
  logic in_range_d;

  // stage two: answer on the port
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // true when an access names instance idx
  function automatic logic inst_match(input logic [3:0] inst, input int idx);
    return (int'(inst) == idx);
  endfunction

  // true when an access names an instance that exists
  function automatic logic inst_exists(input logic [3:0] inst);
    return (int'(inst) < NUM_INST);
  endfunction

  // write enables: only the named instance may change
  for (genvar i = 0; i < NUM_INST; i++) begin : g_wr_en
    assign wr_en[i] = cfg_in.valid && cfg_in.write && inst_match(cfg_in.inst, i);
  end

  // one instance per agent, each with private registers
  for (genvar i = 0; i < NUM_INST; i++) begin : g_inst
    llpes_inst #(
      .HUB_SIDE(HUB_SIDE)
    ) u_inst (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .wr_en_in(wr_en[i]),
      .reg_sel_in(cfg_in.reg_sel),
      .part_in(cfg_in.part),
      .wdata_in(cfg_in.wdata),
      .evt_in(evt_in[i]),
      .rdata_out(inst_rdata[i]),
      .hit_out(inst_hit[i])
    );
  end

  // hit pairs onto the output, register a in the even bit
  for (genvar i = 0; i < NUM_INST; i++) begin : g_hit
    assign event_hit_out[2*i] = inst_hit[i][0];
    assign event_hit_out[2*i+1] = inst_hit[i][1];
  end

  // read select: one-hot copy of the instance held in stage one
  for (genvar i = 0; i < NUM_INST; i++) begin : g_rd_sel
    assign rd_sel[i] = inst_match(rd_inst_q, i);
  end

  // stage one next values
  always_comb begin
    pend_d = cfg_in.valid;
    write_d = cfg_in.write;
    rd_inst_d = cfg_in.inst;
    in_range_d = inst_exists(cfg_in.inst);
  end

  // stage one registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_q <= 1'b0;
      write_q <= 1'b0;
      rd_inst_q <= 4'h0;
      in_range_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      write_q <= write_d;
      rd_inst_q <= rd_inst_d;
      in_range_q <= in_range_d;
    end
  end

  // stage two next values; one-hot pick so a stray number never reads past the array
  always_comb begin
    ack_d = pend_q;
    rdata_d = 32'h00000000;
    if (pend_q && !write_q && in_range_q) begin
      for (int k = 0; k < NUM_INST; k++) begin
        if (rd_sel[k]) begin
          rdata_d = inst_rdata[k];
        end
      end
    end
  end

  // stage two registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // port outputs straight from stage two
  assign cfg_ack_out = ack_q;
  assign cfg_rdata_out = rdata_q;

endmodule

/* File: verif/llpes_chk.sv */
// Purpose: port checks for llpes_top
// Assumes: single clock domain
// Notes: bound below
`timescale 1ns/1ps
module llpes_chk
  import llpes_pkg::*;
#(parameter int NUM_INST = 4) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire llpes_cfg_type cfg_in,
  input wire llpes_ob_evt_type evt_in [NUM_INST],
  input wire logic cfg_ack_out,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic [2*NUM_INST-1:0] event_hit_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // answer timing and content
  a_ack_two: assert property (cfg_in.valid |-> ##2 cfg_ack_out) else $error("ack late");
  a_ack_cause: assert property (cfg_ack_out |-> $past(cfg_in.valid, 2)) else $error("stray ack");
  a_wr_zero: assert property (cfg_ack_out && $past(cfg_in.write, 2) |-> cfg_rdata_out == 32'h0)
    else $error("write data");
  a_high_bit: assert property (cfg_ack_out && $past(cfg_in.part, 2) |-> cfg_rdata_out[31:1] == 31'h0)
    else $error("high part");
  a_range_zero: assert property (cfg_ack_out && $past(cfg_in.inst, 2) >= NUM_INST |-> !cfg_rdata_out)
    else $error("range");
  // a hit needs traffic one cycle before
  a_hit_cause: assert property (event_hit_out[1:0] != 2'h0 |-> $past(evt_in[0]) != '0)
    else $error("stray hit");
endmodule
bind llpes_top llpes_chk #(.NUM_INST(NUM_INST)) chk_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .cfg_in(cfg_in), .evt_in(evt_in), .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out),
  .event_hit_out(event_hit_out));

/* File: verif/llpes_cnt_model.sv */
// Purpose: counter behind the hit outputs
// Assumes: one count per hit bit
// Notes: all instances summed
`timescale 1ns/1ps
module llpes_cnt_model #(parameter int W = 8) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] hit_in,
  output int unsigned total_out
);
  // accumulate hit pulses
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) total_out <= 0;
    else total_out <= total_out + $countones(hit_in);
  end
endmodule

/* File: verif/llpes_top_tb.sv */
// Purpose: directed checks of llpes_top
// Assumes: four coherent-side instances and two hub-side ones
// Notes: inputs move 1 ns after edges
`timescale 1ns/1ps
module llpes_top_tb;
  import llpes_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  llpes_cfg_type cfg = '0;
  llpes_ob_evt_type evt [4] = '{default: '0};
  logic ack;
  logic [31:0] rd;
  logic [7:0] hit;
  int unsigned total;
  int error_cnt = 0;
  int checked = 0;
  int hits = 0;
  llpes_cfg_type cfg_h = '0;
  llpes_ob_evt_type evt_h [2] = '{default: '0};
  logic ack_h;
  logic [31:0] rd_h;
  logic [3:0] hit_h;
  // clock and parts
  always #50 clk = ~clk;
  llpes_top uut (.sys_clk_in(clk), .reset_n_in(rst_n), .cfg_in(cfg), .evt_in(evt),
    .cfg_ack_out(ack), .cfg_rdata_out(rd), .event_hit_out(hit));
  llpes_top #(.NUM_INST(2), .HUB_SIDE(1'b1)) uut_hub (.sys_clk_in(clk), .reset_n_in(rst_n), .cfg_in(cfg_h),
    .evt_in(evt_h), .cfg_ack_out(ack_h), .cfg_rdata_out(rd_h), .event_hit_out(hit_h));
  llpes_cnt_model far (.sys_clk_in(clk), .reset_n_in(rst_n), .hit_in(hit), .total_out(total));
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one access on either unit, answer stands for the cycle after the second edge
  task automatic op(input logic w, input logic [3:0] n, input logic r, input llpes_part_type p,
    input logic [31:0] d, input logic [31:0] e, input bit hb = 1'b0);
    if (hb) cfg_h = '{1'b1, w, n, r, p, d};
    else cfg = '{1'b1, w, n, r, p, d};
    @(posedge clk) #1;
    cfg.valid = 1'b0;
    cfg_h.valid = 1'b0;
    @(posedge clk) #1;
    if (hb) chk({ack_h, rd_h}, {1'b1, e});
    else chk({ack, rd}, {1'b1, e});
  endtask
  // set instance 0 register a, fire one traffic cycle
  task automatic ev(input logic [32:0] s, input logic [3:0] l, input logic h);
    op(1'b1, 4'h0, 1'b0, LLPES_PART_LOW, s[31:0], 32'h0);
    op(1'b1, 4'h0, 1'b0, LLPES_PART_HIGH, {31'h0, s[32]}, 32'h0);
    evt[0] = '{1'b1, 1'b1, l, 1'b1};
    @(posedge clk) #1 evt[0] = '0;
    chk({25'h0, hit}, {32'h0, h});
    hits += h;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    op(1'b0, 4'h2, 1'b1, LLPES_PART_HIGH, 32'h0, 32'h0);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 4'(k / 2), k[0], LLPES_PART_LOW, 32'h00C0_0000 + k, 32'h0);
      op(1'b1, 4'(k / 2), k[0], LLPES_PART_HIGH, 32'(k % 2), 32'h0);
    end
    op(1'b1, 4'h4, 1'b0, LLPES_PART_LOW, 32'hFFFF_FFFF, 32'h0);
    for (int k = 0; k < 8; k++) begin
      op(1'b0, 4'(k / 2), k[0], LLPES_PART_LOW, 32'h0, 32'h00C0_0000 + k);
      op(1'b0, 4'(k / 2), k[0], LLPES_PART_HIGH, 32'h0, 32'(k % 2));
    end
    op(1'b0, 4'h4, 1'b0, LLPES_PART_LOW, 32'h0, 32'h0);
    for (int c = 0; c < 6; c++) ev({5'h13, 3'(c), 25'h0}, 4'hF, c inside {[1:4]});
    ev({5'h0D, 3'h3, 25'h0}, 4'h2, 1'b0);
    ev({5'h0D, 3'h3, 25'h0}, 4'h1, 1'b1);
    ev({5'h0E, 3'h3, 25'h0}, 4'h1, 1'b0);
    ev({5'h0F, 3'h3, 25'h0}, 4'h4, 1'b1);
    ev({5'h10, 3'h3, 25'h0}, 4'h7, 1'b0);
    ev({5'h11, 3'h3, 25'h0}, 4'h2, 1'b1);
    ev({5'h12, 3'h3, 25'h0}, 4'h4, 1'b1);
    ev({5'h1F, 3'h3, 25'h0}, 4'h1, 1'b1);
    ev({5'h14, 3'h3, 25'h0}, 4'hF, 1'b0);
    chk(33'(total), 33'(hits));
    // hub-side unit: two instances, hub-only lane code honoured
    op(1'b1, 4'h1, 1'b1, LLPES_PART_LOW, 32'h4600_0000, 32'h0, 1'b1);
    op(1'b1, 4'h1, 1'b1, LLPES_PART_HIGH, 32'h1, 32'h0, 1'b1);
    op(1'b0, 4'h1, 1'b1, LLPES_PART_LOW, 32'h0, 32'h4600_0000, 1'b1);
    op(1'b0, 4'h1, 1'b1, LLPES_PART_HIGH, 32'h0, 32'h1, 1'b1);
    op(1'b0, 4'h2, 1'b1, LLPES_PART_LOW, 32'h0, 32'h0, 1'b1);
    evt_h[1] = '{1'b0, 1'b0, 4'h8, 1'b0};
    @(posedge clk) #1 evt_h[1] = '0;
    chk({29'h0, hit_h}, {29'h0, 4'h8});
    give_verdict();
  end
endmodule
